// ---- design/mhcs_regs.svh ----
`ifndef MHCS_REGS_SVH
`define MHCS_REGS_SVH

// Register byte addresses
`define MHCS_CTL_OFS      12'h000
`define MHCS_STAT_OFS     12'h004
// Control field positions
`define MHCS_ODIS_BIT     7
`define MHCS_POL_BIT      6
`define MHCS_SYNC_BIT     5
`define MHCS_SEL_MSB      3
`define MHCS_SEL_LSB      0
// Control reset value and writable mask (bit 4 reads as zero)
`define MHCS_CTL_RST      8'h00
`define MHCS_CTL_MASK     8'hEF
// Carrier select codes
`define MHCS_SEL_GND      4'h0
`define MHCS_SEL_PIN_A    4'h1
`define MHCS_SEL_PIN_B    4'h2
`define MHCS_SEL_REFCLK   4'h3
`define MHCS_SEL_CCP      4'h4
`define MHCS_SEL_RSV_MIN  4'h5
// Status field positions
`define MHCS_STAT_HIGH    0
`define MHCS_STAT_CAR     1

`endif

// ---- design/mhcs_pkg.sv ----
package mhcs_pkg;

   // Which carrier time the modulator is in
   typedef enum logic [1:0] {
      MHCS_HIGH = 2'b01,
      MHCS_LOW  = 2'b10
   } mhcs_state_t;

endpackage

// ---- design/mhcs_sync.sv ----
`timescale 1ns/1ps
// Two-stage synchroniser for pins from outside the clock domain
module mhcs_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   // First stage feeds only the second stage
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         meta_r   <= '0;
         sync_out <= '0;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule

// ---- design/mhcs_top.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Output-disable bit blocks carrier drive to pin
// (R2) Invert bit inverts the selected high carrier
// (R3) Sync set: leave high carrier on falling edge
// (R4) Sync clear: leave high carrier at once
// (R5) Four-bit select field in low register bits
// (R6) Code 0100 routes capture/compare PWM output
// (R7) Codes 0101 and above connect nothing
// (R8) Codes 0000-0011: ground, pin a, b, refclk
`include "mhcs_regs.svh"

module mhcs_top
   import mhcs_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rst_b,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        carrier_input_pin_a,
   input  wire logic        carrier_input_pin_b,
   input  wire logic        ref_clock_out,
   input  wire logic        capture_compare_unit,
   input  wire logic        mod_data_high,
   output logic             high_carrier_r,
   output logic             high_time_active_r,
   output logic             high_carrier_pin_r,
   output logic             high_carrier_pin_en_r
);
   logic [7:0]  high_carrier_control_r;
   logic [1:0]  pins_sync;
   logic        raw_carrier;
   logic        carrier_prev_r;
   logic        carrier_fall;
   logic        access;
   logic        hit_ctl;
   logic        hit_stat;
   logic [31:0] rdata_nxt;
   mhcs_state_t state_r;

   wire odis_bit = high_carrier_control_r[`MHCS_ODIS_BIT];
   wire pol_bit  = high_carrier_control_r[`MHCS_POL_BIT];
   wire sync_bit = high_carrier_control_r[`MHCS_SYNC_BIT];
   wire [3:0] sel_field = high_carrier_control_r[`MHCS_SEL_MSB:`MHCS_SEL_LSB];

   // Carrier pins come from outside the clock domain
   mhcs_sync #(.WIDTH(2)) u_pin_sync (
      .clock    (clock),
      .rst_b    (rst_b),
      .async_in ({carrier_input_pin_b, carrier_input_pin_a}),
      .sync_out (pins_sync)
   );

   // APB decode; one wait state before pready
   assign access   = psel && penable && pready;
   assign hit_ctl  = (paddr == `MHCS_CTL_OFS);
   assign hit_stat = (paddr == `MHCS_STAT_OFS);

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pready <= 1'b0;
      end else begin
         pready <= psel && penable && !pready;
      end
   end

   // Error flag for unmapped addresses
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= psel && penable && !pready && !hit_ctl && !hit_stat;
      end
   end

   // Control register write; bit 4 is not stored
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         high_carrier_control_r <= `MHCS_CTL_RST;
      end else if (access && pwrite && hit_ctl) begin
         high_carrier_control_r <= pwdata[7:0] & `MHCS_CTL_MASK; // R5
      end
   end

   // Read data mux
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (hit_ctl) begin
         rdata_nxt[7:0] = high_carrier_control_r;
      end else if (hit_stat) begin
         rdata_nxt[`MHCS_STAT_HIGH] = high_time_active_r;
         rdata_nxt[`MHCS_STAT_CAR]  = high_carrier_r;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready && !pwrite) begin
         prdata <= rdata_nxt;
      end
   end

   // Carrier source select
   always_comb begin
      unique case (sel_field)
         `MHCS_SEL_GND:    raw_carrier = 1'b0;                 // R8
         `MHCS_SEL_PIN_A:  raw_carrier = pins_sync[0];         // R8
         `MHCS_SEL_PIN_B:  raw_carrier = pins_sync[1];         // R8
         `MHCS_SEL_REFCLK: raw_carrier = ref_clock_out;        // R8
         `MHCS_SEL_CCP:    raw_carrier = capture_compare_unit; // R6
         default:          raw_carrier = 1'b0;                 // R7
      endcase
   end

   // Polarity applied to the selected carrier
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         high_carrier_r <= 1'b0;
         carrier_prev_r <= 1'b0;
      end else begin
         high_carrier_r <= raw_carrier ^ pol_bit; // R2
         carrier_prev_r <= high_carrier_r;
      end
   end

   assign carrier_fall = carrier_prev_r && !high_carrier_r;

   // High/low time switching, optionally aligned to a falling edge
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_r <= MHCS_LOW;
      end else begin
         unique case (state_r)
            MHCS_HIGH: begin
               if (!mod_data_high && (!sync_bit || carrier_fall)) begin // R3 R4
                  state_r <= MHCS_LOW;
               end
            end
            MHCS_LOW: begin
               if (mod_data_high) begin
                  state_r <= MHCS_HIGH;
               end
            end
            default: state_r <= MHCS_LOW;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         high_time_active_r <= 1'b0;
      end else begin
         high_time_active_r <= (state_r == MHCS_HIGH);
      end
   end

   // Peripheral pin drive, gated by the output-disable bit
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         high_carrier_pin_r    <= 1'b0;
         high_carrier_pin_en_r <= 1'b0;
      end else begin
         high_carrier_pin_r    <= odis_bit ? 1'b0 : high_carrier_r; // R1
         high_carrier_pin_en_r <= !odis_bit;                        // R1
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);

   AST_PIN_DISABLE: assert property ($past(odis_bit) |-> // R1
         !high_carrier_pin_en_r && !high_carrier_pin_r)
      else $error("pin driven while output disabled");
   AST_PIN_FOLLOW: assert property ($past(rst_b) && !$past(odis_bit) |-> // R1
         high_carrier_pin_en_r && high_carrier_pin_r == $past(high_carrier_r))
      else $error("pin does not follow carrier");
   AST_INVERT: assert property ($stable(sel_field) && sel_field == `MHCS_SEL_GND // R2
         |=> high_carrier_r == $past(pol_bit))
      else $error("ground carrier polarity wrong");
   AST_SYNC_HOLD: assert property (state_r == MHCS_HIGH && sync_bit // R3
         && !mod_data_high && !carrier_fall |=> state_r == MHCS_HIGH)
      else $error("left high time without falling edge");
   AST_SYNC_SWITCH: assert property (state_r == MHCS_HIGH && sync_bit // R3
         && !mod_data_high && carrier_fall |=> state_r == MHCS_LOW ##1 !high_time_active_r)
      else $error("no switch on falling edge");
   AST_NOSYNC: assert property (state_r == MHCS_HIGH && !sync_bit // R4
         && !mod_data_high |=> state_r == MHCS_LOW)
      else $error("unsynchronised switch delayed");
   AST_SEL_FIELD: assert property (access && pwrite && hit_ctl // R5
         |=> sel_field == $past(pwdata[3:0]) && !high_carrier_control_r[4])
      else $error("select field not stored");
   AST_CCP: assert property (sel_field == `MHCS_SEL_CCP // R6
         |=> high_carrier_r == ($past(capture_compare_unit) ^ $past(pol_bit)))
      else $error("capture unit not routed");
   AST_RESERVED: assert property (sel_field >= `MHCS_SEL_RSV_MIN // R7
         |=> high_carrier_r == $past(pol_bit))
      else $error("reserved code connected a source");
   AST_PIN_A: assert property (sel_field == `MHCS_SEL_PIN_A // R8
         |=> high_carrier_r == ($past(pins_sync[0]) ^ $past(pol_bit)))
      else $error("pin a not routed");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");

   // Remaining select codes, the bus answer and unmapped writes
   AST_PIN_B: assert property (sel_field == `MHCS_SEL_PIN_B // R8
         |=> high_carrier_r == ($past(pins_sync[1]) ^ $past(pol_bit)))
      else $error("pin b not routed");
   AST_REFCLK: assert property (sel_field == `MHCS_SEL_REFCLK // R8
         |=> high_carrier_r == ($past(ref_clock_out) ^ $past(pol_bit)))
      else $error("reference clock not routed");
   AST_READY_ANSWER: assert property (psel && penable && !pready |=> pready)
      else $error("no answer one cycle into the access phase");
   AST_UNMAPPED_WRITE: assert property (access && pwrite && !hit_ctl // R5
         |=> $stable(high_carrier_control_r))
      else $error("control changed by a write elsewhere");

endmodule

// ---- tb/mhcs_src_model.sv ----
`timescale 1ns/1ps
// Carrier sources and pins that feed the high carrier path
module mhcs_src_model (
   input  wire logic clock,
   output logic      pin_a,
   output logic      pin_b,
   output logic      refclk,
   output logic      ccp
);
   logic [7:0] cnt_r = 8'h00;
   initial {pin_a, pin_b, refclk, ccp} = 4'h0;
   // Free-running sources with unrelated periods
   always @(posedge clock) begin
      cnt_r  <= cnt_r + 8'h01;
      refclk <= cnt_r[1];
      ccp    <= (cnt_r % 8'h03) == 8'h00;
      pin_a  <= (cnt_r % 8'h06) < 8'h03;
      pin_b  <= (cnt_r % 8'h0A) < 8'h05;
   end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import mhcs_pkg::*;
   logic        clock = 1'b0, rst_b = 1'b0, mdh = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, rsp_err, pa, pb, rc, cc, hc, ha, hp, he;
   logic [3:0]  h_a, h_b, h_r, h_c;
   int          n_fail = 0, samples_checked = 0, cyc = 0;
   always #20 clock = ~clock;
   mhcs_src_model mhcs_src_model_i (.clock(clock), .pin_a(pa), .pin_b(pb), .refclk(rc), .ccp(cc));
   mhcs_top mhcs_top_i (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .carrier_input_pin_a(pa), .carrier_input_pin_b(pb),
      .ref_clock_out(rc), .capture_compare_unit(cc), .mod_data_high(mdh),
      .high_carrier_r(hc), .high_time_active_r(ha), .high_carrier_pin_r(hp),
      .high_carrier_pin_en_r(he));
   // Source history and run-time ceiling
   always @(posedge clock) begin
      h_a <= {h_a[2:0], pa};
      h_b <= {h_b[2:0], pb};
      h_r <= {h_r[2:0], rc};
      h_c <= {h_c[2:0], cc};
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("mismatches %0d of %0d checks", n_fail, samples_checked);
      if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      rsp_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Expected carrier for a control value, pins lag two more cycles
   function automatic logic exp_car(input logic [7:0] c);
      logic s;
      case (c[3:0])
         4'h1: s = h_a[2];
         4'h2: s = h_b[2];
         4'h3: s = h_r[0];
         4'h4: s = h_c[0];
         default: s = 1'b0;
      endcase
      return s ^ c[6];
   endfunction
   // Every select code, plain and inverted; pin follows carrier
   task automatic t_select();
      logic [7:0] ctl;
      logic       p;
      for (int c = 0; c < 32; c++) begin
         ctl = {1'b0, c[4], 2'b00, c[3:0]};
         apb(1'b1, 12'h000, {24'h0, ctl});
         apb(1'b0, 12'h000, 32'h0);
         check(rd, {24'h0, ctl});
         #1;
         repeat (6) begin
            p = hc;
            @(posedge clock);
            #1;
            check(hc, exp_car(ctl));
            check({he, hp}, {1'b1, p});
         end
      end
   endtask
   task automatic t_disable();
      apb(1'b1, 12'h000, 32'h93);
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'h83);
      repeat (6) begin
         @(posedge clock);
         #1;
         check({he, hp}, 2'b00);
      end
   endtask
   // Leaving high time with and without waiting for a falling edge
   task automatic t_sync();
      int k;
      apb(1'b1, 12'h000, 32'h20);
      mdh <= 1'b1;
      repeat (3) @(posedge clock);
      mdh <= 1'b0;
      repeat (10) @(posedge clock);
      #1;
      check(ha, 1'b1);
      apb(1'b0, 12'h004, 32'h0);
      check(rd, 32'h1);
      apb(1'b1, 12'h000, 32'h23);
      k = 0;
      while (ha !== 1'b0 && k < 12) begin
         @(posedge clock);
         #1;
         k++;
      end
      check(ha, 1'b0);
      apb(1'b1, 12'h000, 32'h03);
      mdh <= 1'b1;
      repeat (3) @(posedge clock);
      mdh <= 1'b0;
      @(posedge clock);
      #1;
      check(ha, 1'b1);
      @(posedge clock);
      #1;
      check(ha, 1'b0);
   endtask
   task automatic t_unmapped();
      apb(1'b1, 12'h008, 32'hFF);
      check(rsp_err, 1'b1);
      apb(1'b0, 12'h008, 32'h0);
      check({rsp_err, rd}, {1'b1, 32'h0});
      apb(1'b0, 12'h000, 32'h0);
      check(rd, 32'h03);
   endtask
   initial begin
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      check({he, rd}, {1'b1, 32'h0});
      t_select();
      t_disable();
      t_sync();
      t_unmapped();
      give_verdict();
   end
endmodule
